// file: rtl/ace_executor.sv
// ATA command executor: task file, command sequencer and read data path
// Contract
// - Nop aborts, task file left untouched
// - Codes 1xh recalibrate, BSY set, seek to zero
// - Recalibrate done: BSY clear, interrupt, cylinder zero
// - Flush holds BSY until cache committed, interrupts
// - Alternate flush opcode behaves as flush
// - Read sets BSY, implied seek, 1-256 sectors
// - Sector buffered: set DRQ and interrupt
// - After each sector but the last: DRQ clear, BSY set
// - Uncorrectable sector delivered, then stop at it
// - Interrupt per sector, none after last
// - Read end: count zero, last position kept
// - Read-log subcommand limits reported error bits
// - Off-line subcommand limits reported error bits
// - Max-address subcommands: ERR, ABRT only, no DF
module ace_executor #(
  parameter int SECTOR_WORDS = 256,
  parameter int FIFO_DEPTH = 32,
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEAD_COUNT = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ace_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic intrq_o,
  output logic seek_start_o,
  output logic [15:0] seek_cyl_o,
  input wire logic seek_done_i,
  input wire logic seek_fail_i,
  output logic flush_start_o,
  input wire logic flush_done_i,
  output logic read_start_o,
  input wire logic sector_found_i,
  input wire logic sector_idnf_i,
  input wire logic sector_uncorr_i,
  input wire logic sector_corrected_data_flag_i,
  input wire logic drive_fault_i,
  input wire logic media_valid_i,
  output logic media_ready_o,
  input wire logic [15:0] media_data_i
);
  import ace_pkg::*;

  ace_state_t state; // Sequencer state
  logic bsy; // Busy status
  logic drq; // Data request status
  logic err_st; // Error status
  logic corrected; // Corrected-data status
  logic fault_q; // Registered drive fault level
  logic df_block; // Suppress fault report for this command
  logic uncorr_pend; // Current sector is uncorrectable
  logic intrq; // Host interrupt level
  logic [7:0] error_reg;
  logic [7:0] allow_q; // Error bits this command may report
  logic [7:0] feature_reg;
  logic [7:0] sector_count_reg;
  logic [7:0] sector_number_reg;
  logic [15:0] cylinder_position_reg;
  logic [3:0] head_number_reg;
  logic [3:0] drive_select_reg; // Upper nibble of drive/head
  logic [15:0] head_cyl; // Cylinder the heads sit on
  logic [15:0] word_cnt; // Words of this sector handed out
  logic [7:0] status_byte;
  logic [31:0] rd_mux;
  logic [15:0] step_cyl;
  logic [3:0] step_head;
  logic [7:0] step_sect;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic [2:0] idx;
  logic [7:0] cmd_code;
  logic [7:0] allow_now;
  logic mapped, data_rd, acc, wr, rd, tf_wr, cmd_wr, pop, stat_rd;
  logic is_recal, is_flush, is_read, is_other;
  logic last_word, sect_end, more, ev_irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  assign idx = wb_adr_i[IDX_LSB+2:IDX_LSB];
  assign mapped = ~wb_adr_i[ADR_W-1];
  assign data_rd = mapped & ~wb_we_i & (idx == REG_DATA);
  // A data read under DRQ waits for a word, stalling the bus
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & (~data_rd | ~drq | fifo_valid);
  assign wr = acc & wb_we_i & wb_sel_i[0] & mapped;
  assign rd = acc & ~wb_we_i & mapped;
  // Writes while busy or mid-transfer are dropped
  assign tf_wr = wr & ~bsy & ~drq & (state == S_IDLE);
  assign cmd_wr = tf_wr & (idx == REG_STAT_CMD);
  assign stat_rd = rd & (idx == REG_STAT_CMD);
  assign pop = rd & (idx == REG_DATA) & drq & fifo_valid;
  assign cmd_code = wb_dat_i[7:0];

  // Command classes
  assign is_recal = (cmd_code[7:4] == CMD_RECAL_NIB);
  assign is_flush = (cmd_code == CMD_FLUSH) | (cmd_code == CMD_FLUSH_ALT);
  assign is_read = (cmd_code == CMD_READ) | (cmd_code == CMD_READ_NR);
  // Nop, unknown and unsupported subcommands all end aborted
  assign is_other = ~is_recal & ~is_flush & ~is_read;

  // Error bits a command may report
  always_comb
  begin
    allow_now = ER_ALL;
    if (cmd_code == CMD_SMART && feature_reg == FEAT_RD_LOG)
      allow_now = MASK_RD_LOG;
    else if (cmd_code == CMD_SMART && feature_reg == FEAT_OFFLINE)
      allow_now = MASK_OFFLINE;
    else if (cmd_code == CMD_SET_MAX && feature_reg >= FEAT_MAX_PW && feature_reg <= FEAT_MAX_FRZ)
      allow_now = MASK_SET_MAX;
  end

  // Sector progress
  assign last_word = (word_cnt == 16'(SECTOR_WORDS - 1));
  assign sect_end = (state == S_RXFER) & pop & last_word;
  // Count zero means 256, so only one is the last
  assign more = (sector_count_reg != CNT_LAST);

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      bsy <= 1'b0;
      drq <= 1'b0;
      seek_start_o <= 1'b0;
      flush_start_o <= 1'b0;
      read_start_o <= 1'b0;
      seek_cyl_o <= CYL_ZERO;
    end
    else
    begin
      seek_start_o <= 1'b0;
      flush_start_o <= 1'b0;
      read_start_o <= 1'b0;
      unique case (state)
        S_IDLE:
          if (cmd_wr && is_recal)
          begin
            state <= S_RECAL;
            bsy <= 1'b1;
            seek_start_o <= 1'b1;
            seek_cyl_o <= CYL_ZERO;
          end
          else if (cmd_wr && is_flush)
          begin
            state <= S_FLUSH;
            bsy <= 1'b1;
            flush_start_o <= 1'b1;
          end
          else if (cmd_wr && is_read)
          begin
            bsy <= 1'b1;
            // Implied seek only when off the target track
            if (cylinder_position_reg != head_cyl)
            begin
              state <= S_RSEEK;
              seek_start_o <= 1'b1;
              seek_cyl_o <= cylinder_position_reg;
            end
            else
            begin
              state <= S_RWAIT;
              read_start_o <= 1'b1;
            end
          end
        S_RECAL:
          if (seek_done_i)
          begin
            state <= S_IDLE;
            bsy <= 1'b0;
          end
        S_FLUSH:
          // Held busy until the cache reports committed
          if (flush_done_i)
          begin
            state <= S_IDLE;
            bsy <= 1'b0;
          end
        S_RSEEK:
          if (seek_done_i && seek_fail_i)
          begin
            state <= S_IDLE;
            bsy <= 1'b0;
          end
          else if (seek_done_i)
          begin
            state <= S_RWAIT;
            read_start_o <= 1'b1;
          end
        S_RWAIT:
          if (sector_idnf_i)
          begin
            state <= S_IDLE;
            bsy <= 1'b0;
          end
          else if (sector_found_i)
          begin
            state <= S_RXFER;
            bsy <= 1'b0;
            drq <= 1'b1;
          end
        S_RXFER:
          if (sect_end)
          begin
            drq <= 1'b0;
            // An uncorrectable sector ends the command after delivery
            if (uncorr_pend || !more)
              state <= S_IDLE;
            else
            begin
              state <= S_RWAIT;
              bsy <= 1'b1;
            end
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Track where the heads are, so reads skip needless seeks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      head_cyl <= CYL_ZERO;
    else if ((state == S_RECAL || state == S_RSEEK) && seek_done_i && !seek_fail_i)
      head_cyl <= seek_cyl_o;
  end

  ////////////////////////////////////////////////////////////////////
  // Task file
  ace_addr_step #(
    .SPT(SECTORS_PER_TRACK),
    .HEADS(HEAD_COUNT)
  ) u_step (
    .lba_i(drive_select_reg[DH_LBA]),
    .cyl_i(cylinder_position_reg),
    .head_i(head_number_reg),
    .sect_i(sector_number_reg),
    .next_cyl_o(step_cyl),
    .next_head_o(step_head),
    .next_sect_o(step_sect)
  );

  // Host writes, recalibrate clearing and per-sector stepping
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      feature_reg <= 8'h00;
      sector_count_reg <= CNT_LAST;
      sector_number_reg <= SECT_FIRST;
      cylinder_position_reg <= CYL_ZERO;
      head_number_reg <= 4'h0;
      drive_select_reg <= 4'h0;
    end
    else if (tf_wr)
    begin
      unique case (idx)
        REG_ERR_FEAT: feature_reg <= wb_dat_i[7:0];
        REG_COUNT: sector_count_reg <= wb_dat_i[7:0];
        REG_SECTOR: sector_number_reg <= wb_dat_i[7:0];
        REG_CYL_LO: cylinder_position_reg[7:0] <= wb_dat_i[7:0];
        REG_CYL_HI: cylinder_position_reg[15:8] <= wb_dat_i[7:0];
        REG_DRV_HEAD:
        begin
          drive_select_reg <= wb_dat_i[7:4];
          head_number_reg <= wb_dat_i[3:0];
        end
        default: ; // Data and command leave the task file alone
      endcase
    end
    else if (state == S_RECAL && seek_done_i && !seek_fail_i)
    begin
      cylinder_position_reg <= CYL_ZERO;
      if (drive_select_reg[DH_LBA])
        sector_number_reg <= 8'h00;
    end
    else if (sect_end && !uncorr_pend)
    begin
      sector_count_reg <= sector_count_reg - 8'h01;
      // The last sector's position stays; only step when more follow
      if (more)
      begin
        cylinder_position_reg <= step_cyl;
        head_number_reg <= step_head;
        sector_number_reg <= step_sect;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Error and status outcome
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      error_reg <= ER_NONE;
      err_st <= 1'b0;
      allow_q <= ER_ALL;
      df_block <= 1'b0;
      uncorr_pend <= 1'b0;
      corrected <= 1'b0;
    end
    else if (cmd_wr)
    begin
      allow_q <= allow_now;
      // Fault stays visible only where the command may report it
      df_block <= (cmd_code == CMD_SET_MAX) | (is_other & (allow_now == ER_ALL) & (cmd_code != CMD_NOP));
      uncorr_pend <= 1'b0;
      corrected <= 1'b0;
      error_reg <= is_other ? (ER_ABRT & allow_now) : ER_NONE;
      err_st <= is_other;
    end
    else
    begin
      if (state == S_RECAL && seek_done_i && seek_fail_i)
      begin
        error_reg <= ER_TRK0 & allow_q;
        err_st <= 1'b1;
      end
      if ((state == S_RSEEK && seek_done_i && seek_fail_i) || (state == S_RWAIT && sector_idnf_i))
      begin
        error_reg <= ER_IDNF & allow_q;
        err_st <= 1'b1;
      end
      if (state == S_RWAIT && sector_found_i)
      begin
        uncorr_pend <= sector_uncorr_i;
        corrected <= sector_corrected_data_flag_i;
      end
      if (sect_end && uncorr_pend)
      begin
        error_reg <= ER_UNC & allow_q;
        err_st <= 1'b1;
      end
    end
  end

  // Fault level comes from logic on this clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_q <= 1'b0;
    else
      fault_q <= drive_fault_i;
  end

  // Status byte assembly
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[ST_BSY] = bsy;
    status_byte[ST_DRDY] = 1'b1;
    status_byte[ST_DF] = fault_q & ~df_block;
    status_byte[ST_DSC] = (state != S_RECAL) && (state != S_RSEEK);
    status_byte[ST_DRQ] = drq;
    status_byte[ST_FIXED] = corrected;
    status_byte[ST_ERR] = err_st;
  end

  ////////////////////////////////////////////////////////////////////
  // Host interrupt; a new event beats a clearing status read
  assign ev_irq = (cmd_wr & is_other)
                | (state == S_RECAL & seek_done_i)
                | (state == S_FLUSH & flush_done_i)
                | (state == S_RSEEK & seek_done_i & seek_fail_i)
                | (state == S_RWAIT & (sector_found_i | sector_idnf_i));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      intrq <= 1'b0;
    else if (ev_irq)
      intrq <= 1'b1;
    else if (stat_rd || cmd_wr)
      intrq <= 1'b0;
  end
  assign intrq_o = intrq;

  ////////////////////////////////////////////////////////////////////
  // Sector data path
  ace_fifo #(
    .W(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(cmd_wr),
    .in_valid_i(media_valid_i),
    .in_ready_o(media_ready_o),
    .in_data_i(media_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // Words handed out in the current sector
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (state == S_RWAIT))
      word_cnt <= 16'h0000;
    else if (pop)
      word_cnt <= word_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////
  // Bus answer
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (idx)
      REG_DATA: rd_mux[15:0] = drq ? fifo_data : 16'h0000;
      REG_ERR_FEAT: rd_mux[7:0] = error_reg;
      REG_COUNT: rd_mux[7:0] = sector_count_reg;
      REG_SECTOR: rd_mux[7:0] = sector_number_reg;
      REG_CYL_LO: rd_mux[7:0] = cylinder_position_reg[7:0];
      REG_CYL_HI: rd_mux[7:0] = cylinder_position_reg[15:8];
      REG_DRV_HEAD: rd_mux[7:0] = {drive_select_reg, head_number_reg};
      REG_STAT_CMD: rd_mux[7:0] = status_byte;
    endcase
  end

  // One-cycle ack; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= acc;
      if (rd)
        wb_dat_o <= rd_mux;
      else if (acc)
        wb_dat_o <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence sect_found_s;
    state == S_RWAIT && sector_found_i && !sector_idnf_i;
  endsequence
  sequence sect_ready_s;
    drq && !bsy && intrq;
  endsequence

  nop_abort_a: assert property (cmd_wr && cmd_code == CMD_NOP |=>
    err_st && error_reg == ER_ABRT && $stable(sector_count_reg) && $stable(cylinder_position_reg))
    else $error("nop did not abort cleanly");
  recal_start_a: assert property (cmd_wr && is_recal |=> bsy && seek_start_o && seek_cyl_o == CYL_ZERO)
    else $error("recalibrate did not start a seek");
  recal_done_a: assert property (state == S_RECAL && seek_done_i && !seek_fail_i |=>
    !bsy && intrq && cylinder_position_reg == CYL_ZERO)
    else $error("recalibrate completion wrong");
  flush_hold_a: assert property (state == S_FLUSH && !flush_done_i |=> bsy)
    else $error("flush released busy early");
  alt_flush_a: assert property (cmd_wr && cmd_code == CMD_FLUSH_ALT |=> state == S_FLUSH && flush_start_o)
    else $error("alternate flush not taken");
  read_start_a: assert property (cmd_wr && is_read |=> bsy && (seek_start_o || read_start_o))
    else $error("read did not start");
  sector_ready_a: assert property (sect_found_s |=> sect_ready_s)
    else $error("sector ready not signalled");
  next_sector_a: assert property (sect_end && more && !uncorr_pend |=> bsy && !drq ##1 bsy)
    else $error("next sector preparation wrong");
  uncorr_stop_a: assert property (sect_end && uncorr_pend |=>
    state == S_IDLE && (error_reg & ER_UNC) != ER_NONE && $stable(sector_number_reg))
    else $error("uncorrectable sector did not stop");
  last_sector_a: assert property (sect_end && !more && !uncorr_pend |=>
    (sector_count_reg == CNT_DONE && !$rose(intrq)) [*2])
    else $error("read end wrong");
  err_mask_a: assert property ((error_reg & ~allow_q) == ER_NONE)
    else $error("error bit outside allowed set");
  max_no_df_a: assert property (df_block |-> !status_byte[ST_DF])
    else $error("fault reported for max-address command");
  unknown_cmd_a: assert property (cmd_wr && is_other && allow_now == ER_ALL |=>
    err_st && error_reg == ER_ABRT && intrq && !bsy)
    else $error("unknown command not aborted");
endmodule

// file: pkg/ace_pkg.sv
// Shared constants and types for the ATA command executor
package ace_pkg;
  // Register word indices; byte address is index times four
  localparam int ADR_W = 6;
  localparam int IDX_LSB = 2;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ERR_FEAT = 3'h1;
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_SECTOR = 3'h3;
  localparam logic [2:0] REG_CYL_LO = 3'h4;
  localparam logic [2:0] REG_CYL_HI = 3'h5;
  localparam logic [2:0] REG_DRV_HEAD = 3'h6;
  localparam logic [2:0] REG_STAT_CMD = 3'h7;
  // Command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [3:0] CMD_RECAL_NIB = 4'h1;
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_READ_NR = 8'h21;
  localparam logic [7:0] CMD_FLUSH = 8'he7;
  localparam logic [7:0] CMD_FLUSH_ALT = 8'hea;
  localparam logic [7:0] CMD_SMART = 8'hb0;
  localparam logic [7:0] CMD_SET_MAX = 8'hf9;
  // Subcommand codes held in the feature register
  localparam logic [7:0] FEAT_RD_LOG = 8'hd5;
  localparam logic [7:0] FEAT_OFFLINE = 8'hd4;
  localparam logic [7:0] FEAT_MAX_PW = 8'h01;
  localparam logic [7:0] FEAT_MAX_FRZ = 8'h04;
  // Status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_FIXED = 2;
  localparam int ST_ERR = 0;
  // Error register values
  localparam logic [7:0] ER_NONE = 8'h00;
  localparam logic [7:0] ER_ALL = 8'hff;
  localparam logic [7:0] ER_UNC = 8'h40;
  localparam logic [7:0] ER_IDNF = 8'h10;
  localparam logic [7:0] ER_ABRT = 8'h04;
  localparam logic [7:0] ER_TRK0 = 8'h02;
  localparam logic [7:0] MASK_RD_LOG = ER_UNC | ER_IDNF | ER_ABRT;
  localparam logic [7:0] MASK_OFFLINE = ER_IDNF | ER_ABRT;
  localparam logic [7:0] MASK_SET_MAX = ER_ABRT;
  // Drive/head upper nibble: LBA mode bit
  localparam int DH_LBA = 2;
  localparam logic [7:0] CNT_DONE = 8'h00;
  localparam logic [7:0] CNT_LAST = 8'h01;
  localparam logic [7:0] SECT_FIRST = 8'h01;
  localparam logic [15:0] CYL_ZERO = 16'h0000;
  // Sequencer states, Gray along idle, seek, wait, transfer in that order
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RSEEK = 3'b001,
    S_RWAIT = 3'b011,
    S_RXFER = 3'b010,
    S_FLUSH = 3'b100,
    S_RECAL = 3'b110
  } ace_state_t;
endpackage

// file: rtl/ace_fifo.sv
// Sector data FIFO between the media stream and the host data register
module ace_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // Depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wp; // Write pointer
  logic [AW-1:0] rp; // Read pointer
  logic [AW:0] cnt; // Words held
  logic push;
  logic pop;

  assign in_ready_o = (cnt != (AW + 1)'(DEPTH));
  assign out_valid_o = (cnt != '0);
  assign out_data_o = mem[rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  ////////////////////////////////////////////////////////////////////
  // Storage write
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wp] <= in_data_i;
    end
  end

  // Pointers and fill count; clear drops stale words of an old command
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// file: rtl/ace_addr_step.sv
// Next task-file position after one sector, in CHS or LBA form
module ace_addr_step #(
  parameter int SPT = 63,
  parameter int HEADS = 16
) (
  input wire logic lba_i,
  input wire logic [15:0] cyl_i,
  input wire logic [3:0] head_i,
  input wire logic [7:0] sect_i,
  output logic [15:0] next_cyl_o,
  output logic [3:0] next_head_o,
  output logic [7:0] next_sect_o
);
  import ace_pkg::*;
  logic [27:0] lba_next; // Linear address plus one

  assign lba_next = {head_i, cyl_i, sect_i} + 28'h0000001;

  // Step sector, then head, then cylinder in CHS; LBA carries sector into cylinder, then head
  always_comb
  begin
    next_cyl_o = cyl_i;
    next_head_o = head_i;
    next_sect_o = sect_i + 8'h01;
    if (lba_i)
    begin
      {next_head_o, next_cyl_o, next_sect_o} = lba_next;
    end
    else if (sect_i >= 8'(SPT))
    begin
      next_sect_o = SECT_FIRST;
      if (head_i >= 4'(HEADS - 1))
      begin
        next_head_o = 4'h0;
        next_cyl_o = cyl_i + 16'h0001;
      end
      else
        next_head_o = head_i + 4'h1;
    end
  end
endmodule

// file: testbench/ace_media_model.sv
// Media-side model: seek, flush and sector streaming
module ace_media_model #(
  parameter int WORDS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic seek_start_i,
  input wire logic flush_start_i,
  input wire logic read_start_i,
  input wire logic more_i,
  input wire logic bad_i,
  input wire logic media_ready_i,
  output logic seek_done_o,
  output logic flush_done_o,
  output logic sector_found_o,
  output logic sector_uncorr_o,
  output logic media_valid_o,
  output logic [15:0] media_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int sk, fl, wc; // Seek and flush delays, words sent
  logic run, ph; // Streaming, half-rate phase
  logic [15:0] nw; // Running word number
  ////////////////////////////////////////
  // Half rate so the block sees stalls; idle data shows inverted
  assign media_valid_o = run && ph && wc < WORDS;
  assign media_data_o = media_valid_o ? 16'ha500 + nw : ~(16'ha500 + nw);
  // Delays, stream progress, one found pulse per sector
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sk <= 0;
      fl <= 0;
      wc <= 0;
      run <= 1'b0;
      ph <= 1'b0;
      nw <= 16'h0;
      seek_done_o <= 1'b0;
      flush_done_o <= 1'b0;
      sector_found_o <= 1'b0;
      sector_uncorr_o <= 1'b0;
    end
    else
    begin
      ph <= ~ph;
      sk <= seek_start_i ? 9 : (sk > 0 ? sk - 1 : 0);
      fl <= flush_start_i ? 14 : (fl > 0 ? fl - 1 : 0);
      seek_done_o <= sk == 1;
      flush_done_o <= fl == 1;
      sector_found_o <= run && wc == WORDS;
      sector_uncorr_o <= bad_i && run && wc == WORDS;
      if (run && wc == WORDS)
        run <= 1'b0;
      if (read_start_i || more_i)
      begin
        run <= 1'b1;
        wc <= 0;
      end
      else if (media_valid_o && media_ready_i)
      begin
        wc <= wc + 1;
        nw <= nw + 16'h1;
      end
    end
  end
endmodule

// file: testbench/tb_ace_executor.sv
// Bench for the command executor over Wishbone
module tb_ace_executor;
  timeunit 1ns;
  timeprecision 1ns;
  import ace_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, more = 0, bad = 0, flt = 0;
  logic [3:0] sel = 4'hf;
  logic [5:0] adr = 6'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, irq, sks, skd, fls, fld, rds, fnd, unc, mrdy, mval;
  logic [15:0] mdat, scyl, nw = 16'h0;
  int error_cnt = 0, n_tests = 0;
  logic [15:0] tbl [6] = '{16'h0000, 16'h5500, 16'hb0d5, 16'hb0d4, 16'hf901, 16'hf904};
  ////////////////////////////////////////
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  ace_executor #(.SECTOR_WORDS(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .intrq_o(irq), .seek_start_o(sks), .seek_cyl_o(scyl), .seek_done_i(skd), .seek_fail_i(1'b0),
    .flush_start_o(fls), .flush_done_i(fld), .read_start_o(rds), .sector_found_i(fnd),
    .sector_idnf_i(1'b0), .sector_uncorr_i(unc), .sector_corrected_data_flag_i(1'b0), .drive_fault_i(flt),
    .media_valid_i(mval), .media_ready_o(mrdy), .media_data_i(mdat));
  ace_media_model #(.WORDS(16)) mdl_u (.clk_i(clk_i), .rst_i(rst_i), .seek_start_i(sks),
    .flush_start_i(fls), .read_start_i(rds), .more_i(more), .bad_i(bad), .media_ready_i(mrdy),
    .seek_done_o(skd), .flush_done_o(fld), .sector_found_o(fnd), .sector_uncorr_o(unc),
    .media_valid_o(mval), .media_data_o(mdat));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [2:0] r, input logic [7:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {1'b0, r, 2'b00};
    wdat <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 500);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k >= 500)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [2:0] r, input logic [15:0] e);
    wb(1'b0, r, 8'h0);
    chk(rdat[15:0], e);
  endtask
  // Bounded wait for the interrupt line
  task automatic wi();
    int k;
    for (k = 0; k < 2000 && irq !== 1'b1; k++)
      @(posedge clk_i);
    chk({15'h0, irq}, 16'h1);
    if (k >= 2000)
      print_verdict();
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG_STAT_CMD, 16'h50);
    rd(REG_COUNT, 16'h1);
    // Write without the low byte lane is acked and dropped
    sel <= 4'he;
    wb(1'b1, REG_COUNT, 8'h33);
    sel <= 4'hf;
    rd(REG_COUNT, 16'h1);
    // Nop, unknown and the masked subcommands all abort; fault shown where allowed
    flt <= 1'b1;
    foreach (tbl[i])
    begin
      wb(1'b1, REG_ERR_FEAT, tbl[i][7:0]);
      wb(1'b1, REG_STAT_CMD, tbl[i][15:8]);
      wi();
      rd(REG_STAT_CMD, tbl[i][15:8] inside {CMD_SET_MAX, 8'h55} ? 16'h51 : 16'h71);
      rd(REG_ERR_FEAT, {8'h0, ER_ABRT});
      rd(REG_COUNT, 16'h1);
    end
    flt <= 1'b0;
    // Recalibrate from a nonzero cylinder
    wb(1'b1, REG_CYL_LO, 8'h12);
    wb(1'b1, REG_CYL_HI, 8'h03);
    wb(1'b1, REG_STAT_CMD, 8'h1f);
    wb(1'b0, REG_STAT_CMD, 8'h0);
    chk({15'h0, rdat[ST_BSY]}, 16'h1);
    wi();
    rd(REG_STAT_CMD, 16'h50);
    rd(REG_CYL_LO, 16'h0);
    rd(REG_CYL_HI, 16'h0);
    // Both flush opcodes; the alternate one only to prove compatibility, hosts avoid it
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, REG_STAT_CMD, i ? CMD_FLUSH_ALT : CMD_FLUSH);
      wb(1'b0, REG_STAT_CMD, 8'h0);
      chk({15'h0, rdat[ST_BSY]}, 16'h1);
      wi();
      rd(REG_STAT_CMD, 16'h50);
    end
    // Two clean sectors, then one uncorrectable from sector 5
    for (int t = 0; t < 2; t++)
    begin
      bad <= t;
      if (t)
        wb(1'b1, REG_CYL_LO, 8'h07);
      wb(1'b1, REG_SECTOR, t ? 8'h05 : 8'h01);
      wb(1'b1, REG_COUNT, 8'h02);
      wb(1'b1, REG_STAT_CMD, t ? CMD_READ_NR : CMD_READ);
      for (int s = 0; s < 2 - t; s++)
      begin
        wi();
        rd(REG_STAT_CMD, 16'h58);
        repeat (16)
        begin
          rd(REG_DATA, 16'ha500 + nw);
          nw++;
        end
        if (s == 0 && t == 0)
        begin
          wb(1'b0, REG_STAT_CMD, 8'h0);
          chk({14'h0, rdat[ST_BSY], rdat[ST_DRQ]}, 16'h2);
          more <= 1'b1;
          @(posedge clk_i);
          more <= 1'b0;
        end
      end
      rd(REG_STAT_CMD, t ? 16'h51 : 16'h50);
      rd(t ? REG_ERR_FEAT : REG_COUNT, t ? {8'h0, ER_UNC} : 16'h0);
      if (t)
        rd(REG_SECTOR, 16'h5);
      if (t)
        chk(scyl, 16'h7);
      repeat (30) @(posedge clk_i);
      chk({15'h0, irq}, 16'h0);
    end
    print_verdict();
  end
endmodule
